// >>> nand_page_read_program_engine_bench.sv
// self-checking bench for the flash page host controller
`timescale 1ns/10ps
module nand_page_read_program_engine_bench;
    import nprpe_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic s_arvalid = 1'b0, s_rready = 1'b0, s_awready, s_wready, s_bvalid, s_arready, s_rvalid, rb;
    logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00, io_in;
    logic [31:0] s_wdata = 32'h0, s_rdata, rd_v;
    logic [1:0] s_bresp, s_rresp, rsp;
    nprpe_pins_s pins;
    int error_cnt = 0, n_checks = 0;
    always #50 aclk = ~aclk;
    nprpe_host nprpe_host_i (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hf), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .pins(pins), .io_in(io_in), .rb(rb));
    nprpe_flash_model nprpe_flash_model_i (.pins(pins), .io_in(io_in), .rb(rb));
    // verdict and end of run
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", error_cnt, n_checks);
        if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one axi4-lite write (wr=1) or read (wr=0); readies sampled before the edge that takes them
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic aw, w, ar, b;
        @(posedge aclk);
        if (wr) {s_awaddr, s_wdata, s_awvalid, s_wvalid, s_bready} <= {a, d, 3'b111};
        else {s_araddr, s_arvalid, s_rready} <= {a, 2'b11};
        for (int n = 0; n < 100; n++) begin
            @(negedge aclk);
            {aw, w, ar} = {s_awready, s_wready, s_arready};
            b = wr ? s_bvalid : s_rvalid;
            rsp = wr ? s_bresp : s_rresp;
            rd_v = s_rdata;
            @(posedge aclk);
            if (aw) s_awvalid <= 1'b0;
            if (w) s_wvalid <= 1'b0;
            if (ar) s_arvalid <= 1'b0;
            if (b) begin
                {s_bready, s_rready} <= 2'b00;
                return;
            end
        end
        chk("bus timeout", 32'h1, 32'h0);
        close_out();
    endtask
    // start an operation and poll until it is no longer busy
    task automatic op(input logic [3:0] code);
        xfer(1'b1, REG_CTRL, {28'h0, code});
        for (int n = 0; n < 200; n++) begin
            xfer(1'b0, REG_STAT, 32'h0);
            if (rd_v[STAT_BUSY_BIT] === 1'b0) return;
        end
        chk("op timeout", 32'h1, 32'h0);
        close_out();
    endtask
    task automatic t_program;
        xfer(1'b1, REG_ROW, 32'h41);
        xfer(1'b0, REG_ROW, 32'h0);
        chk("row readback", 32'h41, rd_v);
        xfer(1'b1, REG_COL, 32'h805);
        op(OP_PSET);
        xfer(1'b1, REG_WDATA, 32'ha5);
        op(OP_WBYTE);
        xfer(1'b1, REG_WDATA, 32'h3c);
        op(OP_WBYTE);
        op(OP_RIN);
        xfer(1'b1, REG_WDATA, 32'h96);
        op(OP_WBYTE);
        op(OP_CONF);
        chk("program status", 32'h40, {24'h0, rd_v[15:8]});
    endtask
    task automatic t_read;
        op(OP_READ);
        op(OP_RBYTE);
        chk("first byte", 32'h96, {24'h0, rd_v[23:16]});
        op(OP_RBYTE);
        chk("next byte", 32'h3c, {24'h0, rd_v[23:16]});
        op(OP_ROUT);
        op(OP_RBYTE);
        chk("random out byte", 32'h96, {24'h0, rd_v[23:16]});
    endtask
    task automatic t_status;
        op(OP_STAT);
        chk("status byte", 32'h40, {24'h0, rd_v[15:8]});
        op(OP_RBYTE);
        chk("repeated status", 32'h40, {24'h0, rd_v[23:16]});
        op(OP_RST);
        chk("ready after reset", 32'h4, {29'h0, rd_v[2:0]});
    endtask
    task automatic t_refuse;
        op(OP_CONF);
        chk("confirm refused", 32'h1, {31'h0, rd_v[STAT_REFUSED_BIT]});
        xfer(1'b1, REG_STAT, 32'h2);
        xfer(1'b0, REG_STAT, 32'h0);
        chk("refused cleared", 32'h0, {31'h0, rd_v[STAT_REFUSED_BIT]});
        xfer(1'b0, 8'h3c, 32'h0);
        chk("unmapped resp", 32'h2, {30'h0, rsp});
        xfer(1'b1, 8'h3c, 32'h0);
        chk("unmapped write resp", 32'h2, {30'h0, rsp});
    endtask
    // page order and partial program limit kept by the controller
    task automatic t_order;
        xfer(1'b1, REG_ROW, 32'h40);
        op(OP_PSET);
        chk("lower page refused", 32'h1, {31'h0, rd_v[STAT_REFUSED_BIT]});
        xfer(1'b1, REG_STAT, 32'h2);
        xfer(1'b1, REG_ROW, 32'h41);
        repeat (3) op(OP_PSET);
        chk("fourth partial taken", 32'h0, {31'h0, rd_v[STAT_REFUSED_BIT]});
        op(OP_PSET);
        chk("fifth partial refused", 32'h1, {31'h0, rd_v[STAT_REFUSED_BIT]});
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        chk("idle pins", 32'h1, {31'h0, pins.ce_n & pins.io_oe_n & pins.we_n & pins.re_n});
        t_program();
        t_read();
        t_status();
        t_refuse();
        t_order();
        close_out();
    end
endmodule // nand_page_read_program_engine_bench

// >>> nprpe_flash_model.sv
// behavioural flash device model facing the page host controller
`timescale 1ns/10ps
module nprpe_flash_model import nprpe_pkg::*; (
    input wire nprpe_pins_s pins, // strobes and data from the host
    output logic [7:0] io_in, // data toward the host
    output logic rb // ready, low while busy
);
    logic [7:0] buf_r [0:2111];
    logic [11:0] col_r = 12'h000;
    logic [2:0] acnt_r = 3'h0;
    logic [7:0] dout_r = 8'h00;
    logic stat_r = 1'b0;
    logic load_r = 1'b0;
    initial rb = 1'b1;
    // commands, addresses and data latch on the write strobe rising edge
    always @(posedge pins.we_n) if (!pins.ce_n) begin
        if (pins.cle) begin
            acnt_r = 3'h0;
            stat_r = (pins.io_out == 8'h70); // status until another command
            if (pins.io_out == 8'h30 || pins.io_out == 8'hff || (pins.io_out == 8'h10 && load_r)) begin
                rb <= 1'b0; // busy while page moves, programs or resets
                rb <= #3000 1'b1;
            end
            if (pins.io_out == 8'h80 || pins.io_out == 8'h10) load_r = 1'b0;
        end else if (pins.ale) begin
            if (acnt_r == 3'h0) col_r[7:0] = pins.io_out; // column moves pointer
            if (acnt_r == 3'h1) col_r[11:8] = pins.io_out[3:0];
            acnt_r = acnt_r + 3'h1;
        end else begin
            buf_r[col_r] = pins.io_out; // only loaded bytes change
            col_r = col_r + 12'h001;
            load_r = 1'b1;
        end
    end
    // each read strobe fall gives the next byte, or the status byte
    always @(negedge pins.re_n) if (!pins.ce_n) begin
        dout_r = stat_r ? {1'b0, rb, 6'h00} : buf_r[col_r];
        if (!stat_r) col_r = col_r + 12'h001;
    end
    assign io_in = (!pins.re_n && !pins.ce_n) ? dout_r : ~dout_r; // released bus shows no stale byte
endmodule // nprpe_flash_model

// >>> nprpe_host.sv
// host controller that runs page read and page program sequences on a nand flash
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
module nprpe_host import nprpe_pkg::*; #(
    parameter logic [7:0] CMD_ROUT1 = 8'h05, // random output first command
    parameter logic [7:0] CMD_ROUT2 = 8'he0 // random output second command
) (
    input wire logic aclk, // clock, 10 mhz
    input wire logic aresetn, // synchronous reset, low active
    input wire logic ce, // clock enable, freezes state when low
    input wire logic [7:0] s_awaddr, // write address
    input wire logic s_awvalid, // write address valid
    output logic s_awready, // write address ready
    input wire logic [31:0] s_wdata, // write data
    input wire logic [3:0] s_wstrb, // write byte enables
    input wire logic s_wvalid, // write data valid
    output logic s_wready, // write data ready
    output logic [1:0] s_bresp, // write response
    output logic s_bvalid, // write response valid
    input wire logic s_bready, // write response ready
    input wire logic [7:0] s_araddr, // read address
    input wire logic s_arvalid, // read address valid
    output logic s_arready, // read address ready
    output logic [31:0] s_rdata, // read data
    output logic [1:0] s_rresp, // read response
    output logic s_rvalid, // read data valid
    input wire logic s_rready, // read data ready
    output nprpe_pins_s pins, // flash control and data out
    input wire logic [7:0] io_in, // flash data in
    input wire logic rb // flash ready, low while busy
);
    typedef enum {S_IDLE, S_CMD1, S_ADDR, S_CMD2, S_DATA, S_WB, S_RDY, S_STATCMD, S_STATRD} nprpe_state_e;

    // byte merge under write strobes
    function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // address cycle byte: two column then three row
    function automatic logic [7:0] addr_byte(input logic [2:0] i, input logic [11:0] col, input logic [16:0] row);
        logic [7:0] b;
        b = 8'h00;
        unique case (i)
            3'h0: b = col[7:0];
            3'h1: b = {4'h0, col[11:8]};
            3'h2: b = row[7:0];
            3'h3: b = row[15:8];
            default: b = {7'h00, row[16]};
        endcase
        return b;
    endfunction

    // state after the command and address part
    function automatic nprpe_state_e tail(input logic wt, input logic st);
        return wt ? S_WB : (st ? S_STATCMD : S_IDLE);
    endfunction

    nprpe_state_e state_r, state_nxt;
    nprpe_pins_s pins_r, pins_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [2:0] aidx_r, aidx_nxt, na_r, na_nxt;
    logic [7:0] c1_r, c1_nxt, c2_r, c2_nxt, fstat_r, fstat_nxt, rdat_r, rdat_nxt;
    logic has2_r, has2_nxt, wt_r, wt_nxt, st_r, st_nxt, rd_r, rd_nxt;
    logic setup_r, setup_nxt, loaded_r, loaded_nxt, refused_r, refused_nxt, go_r, go_nxt;
    logic [3:0] op_r, op_nxt, part_r, part_nxt;
    logic [16:0] last_row_r, last_row_nxt;
    logic last_vld_r, last_vld_nxt;
    logic [31:0] col_r, col_nxt, row_r, row_nxt, wd_r, wd_nxt;
    logic [2:0] rb_s_r;
    logic rb_q_r, rb_q_nxt;
    logic [7:0] io_s1_r, io_s2_r, io_s3_r, io_f_r, io_f_nxt;
    logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt, bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [7:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdat_r, wdat_nxt, rdata_r, rdata_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [3:0] wstb_r, wstb_nxt;
    logic aw_rdy_r, aw_rdy_nxt, w_rdy_r, w_rdy_nxt, ar_rdy_r, ar_rdy_nxt;
    logic wr_done, wr_cyc, last_step;
    logic [7:0] byte_out;

    assign pins = pins_r;
    assign s_awready = aw_rdy_r;
    assign s_wready = w_rdy_r;
    assign s_bvalid = bvalid_r;
    assign s_bresp = bresp_r;
    assign s_arready = ar_rdy_r;
    assign s_rvalid = rvalid_r;
    assign s_rdata = rdata_r;
    assign s_rresp = rresp_r;

    // pin filters: a change counts when second and third stage agree
    always_comb begin
        rb_q_nxt = (rb_s_r[1] == rb_s_r[2]) ? rb_s_r[2] : rb_q_r;
        io_f_nxt = (io_s2_r == io_s3_r) ? io_s3_r : io_f_r;
    end

    // bus slave and sequencer next state
    always_comb begin
        state_nxt = state_r; pins_nxt = pins_r; cnt_nxt = cnt_r; aidx_nxt = aidx_r; na_nxt = na_r;
        c1_nxt = c1_r; c2_nxt = c2_r; fstat_nxt = fstat_r; rdat_nxt = rdat_r; has2_nxt = has2_r;
        wt_nxt = wt_r; st_nxt = st_r; rd_nxt = rd_r; setup_nxt = setup_r; loaded_nxt = loaded_r;
        refused_nxt = refused_r; go_nxt = go_r; op_nxt = op_r; part_nxt = part_r;
        last_row_nxt = last_row_r; last_vld_nxt = last_vld_r; col_nxt = col_r; row_nxt = row_r; wd_nxt = wd_r;
        aw_have_nxt = aw_have_r; w_have_nxt = w_have_r; bvalid_nxt = bvalid_r; rvalid_nxt = rvalid_r;
        awaddr_nxt = awaddr_r; wdat_nxt = wdat_r; rdata_nxt = rdata_r; bresp_nxt = bresp_r; rresp_nxt = rresp_r;
        wstb_nxt = wstb_r;
        wr_cyc = 1'b0; wr_done = 1'b0; last_step = 1'b0; byte_out = 8'h00;
        // axi write: address and data in either order, response after both
        if (s_awvalid && s_awready) begin
            aw_have_nxt = 1'b1;
            awaddr_nxt = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            w_have_nxt = 1'b1;
            wdat_nxt = wmask(32'h0, s_wdata, s_wstrb);
            wstb_nxt = s_wstrb; // strobes kept, the bus may move on before the write lands
        end
        if (s_bvalid && s_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (aw_have_r && w_have_r && !bvalid_r) begin
            aw_have_nxt = 1'b0; w_have_nxt = 1'b0; bvalid_nxt = 1'b1; bresp_nxt = 2'b00;
            unique case (awaddr_r)
                REG_CTRL: begin
                    if (state_r == S_IDLE && !go_r) begin
                        go_nxt = 1'b1;
                        op_nxt = wdat_r[3:0];
                    end else begin
                        refused_nxt = 1'b1;
                    end
                end
                REG_COL: col_nxt = wmask(col_r, wdat_r & 32'h0000_0fff, wstb_r);
                REG_ROW: row_nxt = wmask(row_r, wdat_r & 32'h0001_ffff, wstb_r);
                REG_WDATA: wd_nxt = wmask(wd_r, wdat_r & 32'h0000_00ff, wstb_r);
                REG_STAT: if (wdat_r[STAT_REFUSED_BIT]) refused_nxt = 1'b0;
                default: bresp_nxt = 2'b10;
            endcase
        end
        // axi read
        if (s_rvalid && s_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_arvalid && s_arready) begin
            rvalid_nxt = 1'b1; rresp_nxt = 2'b00; rdata_nxt = 32'h0;
            unique case (s_araddr)
                REG_CTRL: rdata_nxt = {28'h0, op_r};
                REG_COL: rdata_nxt = col_r;
                REG_ROW: rdata_nxt = row_r;
                REG_WDATA: rdata_nxt = wd_r;
                REG_STAT: begin
                    rdata_nxt[STAT_BUSY_BIT] = (state_r != S_IDLE) || go_r;
                    rdata_nxt[STAT_REFUSED_BIT] = refused_r;
                    rdata_nxt[STAT_RB_BIT] = rb_q_r;
                    rdata_nxt[STAT_FSTAT_LSB +: 8] = fstat_r;
                    rdata_nxt[STAT_RDATA_LSB +: 8] = rdat_r;
                end
                default: rresp_nxt = 2'b10;
            endcase
        end
        // readys registered from the next handshake state
        aw_rdy_nxt = !aw_have_nxt && !bvalid_nxt;
        w_rdy_nxt = !w_have_nxt && !bvalid_nxt;
        ar_rdy_nxt = !rvalid_nxt;
        // strobe timing: write cycle in three steps, read cycle with a long low phase
        cnt_nxt = cnt_r + 4'h1;
        unique case (state_r)
            S_CMD1, S_CMD2, S_STATCMD: begin
                wr_cyc = 1'b1;
                byte_out = (state_r == S_CMD1) ? c1_r : ((state_r == S_CMD2) ? c2_r : FCMD_STATUS);
            end
            S_ADDR: begin
                wr_cyc = 1'b1;
                byte_out = addr_byte(aidx_r, col_r[11:0], row_r[16:0]);
            end
            S_DATA: begin
                wr_cyc = !rd_r;
                byte_out = wd_r[7:0];
            end
            default: wr_cyc = 1'b0;
        endcase
        if (wr_cyc) begin
            pins_nxt.cle = (state_r == S_CMD1) || (state_r == S_CMD2) || (state_r == S_STATCMD);
            pins_nxt.ale = (state_r == S_ADDR);
            pins_nxt.io_out = byte_out;
            pins_nxt.io_oe_n = 1'b0;
            pins_nxt.we_n = (cnt_r != 4'h1); // data latched at the rising edge
            wr_done = (cnt_r == 4'h2);
        end else if ((state_r == S_DATA && rd_r) || state_r == S_STATRD) begin
            pins_nxt.cle = 1'b0; pins_nxt.ale = 1'b0; pins_nxt.io_oe_n = 1'b1;
            pins_nxt.re_n = (cnt_r >= 4'(RD_LOW_CYC));
            wr_done = (cnt_r == 4'(RD_LOW_CYC));
            if (cnt_r == 4'(RD_LOW_CYC)) begin
                if (state_r == S_STATRD) fstat_nxt = io_f_nxt; // filtered byte settles now
                else rdat_nxt = io_f_nxt;
            end
        end
        if (wr_done) cnt_nxt = 4'h0;
        unique case (state_r)
            S_IDLE: begin
                pins_nxt.ce_n = 1'b1; pins_nxt.cle = 1'b0; pins_nxt.ale = 1'b0;
                pins_nxt.we_n = 1'b1; pins_nxt.re_n = 1'b1; pins_nxt.io_oe_n = 1'b1;
                cnt_nxt = 4'h0; aidx_nxt = 3'h0;
                if (go_r) begin
                    go_nxt = 1'b0;
                    pins_nxt.ce_n = 1'b0;
                    has2_nxt = 1'b0; wt_nxt = 1'b0; st_nxt = 1'b0; rd_nxt = 1'b0; na_nxt = 3'h0;
                    state_nxt = S_CMD1;
                    unique case (op_r)
                        OP_READ: begin // 00h sent even though latched at power-up
                            c1_nxt = FCMD_READ1; c2_nxt = FCMD_READ2; na_nxt = 3'h5; has2_nxt = 1'b1;
                            wt_nxt = 1'b1; setup_nxt = 1'b0; loaded_nxt = 1'b0;
                        end
                        OP_ROUT: begin
                            c1_nxt = CMD_ROUT1; c2_nxt = CMD_ROUT2; na_nxt = 3'h2; has2_nxt = 1'b1;
                        end
                        OP_PSET: begin
                            if (last_vld_r && row_r[16:6] == last_row_r[16:6] && row_r[5:0] < last_row_r[5:0]) begin
                                refused_nxt = 1'b1; state_nxt = S_IDLE;
                            end else if (last_vld_r && row_r[16:0] == last_row_r && part_r >= MAX_PARTIAL) begin
                                refused_nxt = 1'b1; state_nxt = S_IDLE;
                            end else begin
                                c1_nxt = FCMD_LOAD; na_nxt = 3'h5; setup_nxt = 1'b1; loaded_nxt = 1'b0;
                                part_nxt = (last_vld_r && row_r[16:0] == last_row_r) ? part_r + 4'h1 : 4'h1;
                                last_row_nxt = row_r[16:0]; last_vld_nxt = 1'b1;
                            end
                        end
                        OP_RIN: begin // no copy-back is issued, so no sector rule applies
                            c1_nxt = FCMD_RAND_IN; na_nxt = 3'h2;
                            if (!setup_r) begin
                                refused_nxt = 1'b1; state_nxt = S_IDLE;
                            end
                        end
                        OP_WBYTE: begin // only bytes software writes are loaded
                            state_nxt = setup_r ? S_DATA : S_IDLE;
                            if (!setup_r) refused_nxt = 1'b1; // overrides a clear of this cycle
                            loaded_nxt = loaded_r || setup_r;
                        end
                        OP_RBYTE: begin
                            state_nxt = S_DATA; rd_nxt = 1'b1;
                        end
                        OP_CONF: begin
                            c1_nxt = FCMD_PROG; wt_nxt = 1'b1; st_nxt = 1'b1;
                            setup_nxt = 1'b0; loaded_nxt = 1'b0;
                            if (!loaded_r) begin
                                refused_nxt = 1'b1; state_nxt = S_IDLE;
                            end
                        end
                        OP_STAT: state_nxt = S_STATCMD;
                        OP_RST: begin
                            c1_nxt = FCMD_RESET; wt_nxt = 1'b1; setup_nxt = 1'b0; loaded_nxt = 1'b0;
                        end
                        default: begin
                            refused_nxt = 1'b1; state_nxt = S_IDLE;
                        end
                    endcase
                end
            end
            S_CMD1: if (wr_done) state_nxt = (na_r != 3'h0) ? S_ADDR : (has2_r ? S_CMD2 : tail(wt_r, st_r));
            S_ADDR: begin
                last_step = (aidx_r == na_r - 3'h1);
                if (wr_done) begin
                    aidx_nxt = aidx_r + 3'h1;
                    if (last_step) state_nxt = has2_r ? S_CMD2 : tail(wt_r, st_r);
                end
            end
            S_CMD2: if (wr_done) state_nxt = tail(wt_r, st_r);
            S_DATA: if (wr_done) state_nxt = S_IDLE;
            S_WB: begin
                pins_nxt.we_n = 1'b1; pins_nxt.cle = 1'b0; pins_nxt.io_oe_n = 1'b1;
                if (cnt_r >= 4'(WB_CYC + PIN_LAT_CYC)) begin // busy must pass the pin filter first
                    cnt_nxt = 4'h0; state_nxt = S_RDY;
                end
            end
            S_RDY: begin // device busy on its ready pin
                cnt_nxt = 4'h0;
                if (rb_q_r) state_nxt = st_r ? S_STATCMD : S_IDLE;
            end
            S_STATCMD: if (wr_done) state_nxt = S_STATRD;
            S_STATRD: if (wr_done) state_nxt = S_IDLE;
        endcase
    end

    // registers, frozen while the clock enable is low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= S_IDLE; pins_r <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
                io_oe_n: 1'b1, io_out: 8'h00};
            cnt_r <= 4'h0; aidx_r <= 3'h0; na_r <= 3'h0; c1_r <= 8'h00; c2_r <= 8'h00;
            fstat_r <= RESET_STAT; rdat_r <= 8'h00; has2_r <= 1'b0; wt_r <= 1'b0; st_r <= 1'b0; rd_r <= 1'b0;
            setup_r <= 1'b0; loaded_r <= 1'b0; refused_r <= 1'b0; go_r <= 1'b0; op_r <= 4'h0; part_r <= 4'h0;
            last_row_r <= 17'h0; last_vld_r <= 1'b0; col_r <= 32'h0; row_r <= 32'h0; wd_r <= 32'h0;
            rb_s_r <= 3'h7; rb_q_r <= 1'b1; io_s1_r <= 8'h00; io_s2_r <= 8'h00; io_s3_r <= 8'h00; io_f_r <= 8'h00;
            aw_have_r <= 1'b0; w_have_r <= 1'b0; bvalid_r <= 1'b0; rvalid_r <= 1'b0; awaddr_r <= 8'h00;
            wdat_r <= 32'h0; rdata_r <= 32'h0; bresp_r <= 2'b00; rresp_r <= 2'b00;
            wstb_r <= 4'h0; aw_rdy_r <= 1'b0; w_rdy_r <= 1'b0; ar_rdy_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt; pins_r <= pins_nxt; cnt_r <= cnt_nxt; aidx_r <= aidx_nxt; na_r <= na_nxt;
            c1_r <= c1_nxt; c2_r <= c2_nxt; fstat_r <= fstat_nxt; rdat_r <= rdat_nxt; has2_r <= has2_nxt;
            wt_r <= wt_nxt; st_r <= st_nxt; rd_r <= rd_nxt; setup_r <= setup_nxt; loaded_r <= loaded_nxt;
            refused_r <= refused_nxt; go_r <= go_nxt; op_r <= op_nxt; part_r <= part_nxt;
            last_row_r <= last_row_nxt; last_vld_r <= last_vld_nxt; col_r <= col_nxt; row_r <= row_nxt;
            wd_r <= wd_nxt; rb_s_r <= {rb_s_r[1:0], rb}; rb_q_r <= rb_q_nxt;
            io_s1_r <= io_in; io_s2_r <= io_s1_r; io_s3_r <= io_s2_r; io_f_r <= io_f_nxt;
            aw_have_r <= aw_have_nxt; w_have_r <= w_have_nxt; bvalid_r <= bvalid_nxt; rvalid_r <= rvalid_nxt;
            awaddr_r <= awaddr_nxt; wdat_r <= wdat_nxt; rdata_r <= rdata_nxt; bresp_r <= bresp_nxt;
            rresp_r <= rresp_nxt;
            wstb_r <= wstb_nxt; aw_rdy_r <= aw_rdy_nxt; w_rdy_r <= w_rdy_nxt; ar_rdy_r <= ar_rdy_nxt;
        end
    end

    // checks on the sequencing toward the flash
    property p_cmd_order;
        @(posedge aclk) disable iff (!aresetn) (state_r == S_CMD2 && $past(state_r) != S_CMD2) |-> $past(state_r) == S_ADDR;
    endproperty
    a_cmd_order: assert property (p_cmd_order) else $error("second command not after address");
    property p_wait_busy;
        @(posedge aclk) disable iff (!aresetn) (ce && state_r == S_RDY && !rb_q_r) |=> state_r == S_RDY;
    endproperty
    a_wait_busy: assert property (p_wait_busy) else $error("left wait while busy");
    property p_re_low;
        @(posedge aclk) disable iff (!aresetn) $fell(pins_r.re_n) |-> (!pins_r.re_n)[*4];
    endproperty
    a_re_low: assert property (p_re_low) else $error("read strobe low too short");
    property p_partial;
        @(posedge aclk) disable iff (!aresetn) part_r <= MAX_PARTIAL;
    endproperty
    a_partial: assert property (p_partial) else $error("too many partial programs");
    property p_load_first;
        @(posedge aclk) disable iff (!aresetn) (pins_r.cle && !pins_r.we_n && pins_r.io_out == FCMD_PROG) |-> $past(loaded_r, 3);
    endproperty
    a_load_first: assert property (p_load_first) else $error("program confirm without load");
    property p_busy_cmds;
        @(posedge aclk) disable iff (!aresetn) (pins_r.cle && !pins_r.we_n && !rb_q_r) |->
            (pins_r.io_out == FCMD_STATUS || pins_r.io_out == FCMD_RESET);
    endproperty
    a_busy_cmds: assert property (p_busy_cmds) else $error("illegal command while busy");
    property p_stat_read;
        @(posedge aclk) disable iff (!aresetn || !ce) (state_r == S_STATCMD && $past(state_r) != S_STATCMD) |->
            ##[3:4] state_r == S_STATRD ##[5:6] state_r == S_IDLE;
    endproperty
    a_stat_read: assert property (p_stat_read) else $error("status not read back");
    property p_ready_before_idle;
        @(posedge aclk) disable iff (!aresetn) (state_r != S_RDY && $past(state_r) == S_RDY) |-> $past(rb_q_r);
    endproperty
    a_ready_before_idle: assert property (p_ready_before_idle) else $error("left busy wait early");
    property p_ascending;
        @(posedge aclk) disable iff (!aresetn) $changed(last_row_r) && $past(last_vld_r) &&
            last_row_r[16:6] == $past(last_row_r[16:6]) |-> last_row_r[5:0] >= $past(last_row_r[5:0]);
    endproperty
    a_ascending: assert property (p_ascending) else $error("page order descending");
endmodule // nprpe_host

// >>> nprpe_pkg.sv
// shared constants, codes and pin bundle of the flash page host controller
package nprpe_pkg;
    // register byte offsets on the axi4-lite slave
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_COL = 8'h04;
    localparam logic [7:0] REG_ROW = 8'h08;
    localparam logic [7:0] REG_WDATA = 8'h0c;
    localparam logic [7:0] REG_STAT = 8'h10;
    // status register field positions
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_REFUSED_BIT = 1;
    localparam int STAT_RB_BIT = 2;
    localparam int STAT_FSTAT_LSB = 8;
    localparam int STAT_RDATA_LSB = 16;
    // operation codes written to the control register
    localparam logic [3:0] OP_READ = 4'h0;
    localparam logic [3:0] OP_ROUT = 4'h1;
    localparam logic [3:0] OP_PSET = 4'h2;
    localparam logic [3:0] OP_RIN = 4'h3;
    localparam logic [3:0] OP_WBYTE = 4'h4;
    localparam logic [3:0] OP_RBYTE = 4'h5;
    localparam logic [3:0] OP_CONF = 4'h6;
    localparam logic [3:0] OP_STAT = 4'h7;
    localparam logic [3:0] OP_RST = 4'h8;
    // flash command bytes
    localparam logic [7:0] FCMD_READ1 = 8'h00;
    localparam logic [7:0] FCMD_READ2 = 8'h30;
    localparam logic [7:0] FCMD_LOAD = 8'h80;
    localparam logic [7:0] FCMD_RAND_IN = 8'h85;
    localparam logic [7:0] FCMD_PROG = 8'h10;
    localparam logic [7:0] FCMD_STATUS = 8'h70;
    localparam logic [7:0] FCMD_RESET = 8'hff;
    // timing, clock period 100 ns
    localparam int CLK_NS = 100;
    localparam int T_RE_CYCLE_NS = 25;
    localparam int T_WB_NS = 100;
    localparam int RE_LOW_MIN = (T_RE_CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_LOW_CYC = (RE_LOW_MIN > 4) ? RE_LOW_MIN : 4;
    localparam int WB_CYC = ((T_WB_NS + CLK_NS - 1) / CLK_NS < 1) ? 1 : (T_WB_NS + CLK_NS - 1) / CLK_NS;
    localparam int PIN_LAT_CYC = 3; // synchroniser and filter delay on the ready pin
    localparam logic [3:0] MAX_PARTIAL = 4'h4;
    localparam logic [7:0] RESET_STAT = 8'h00;
    // pins driven toward the flash
    typedef struct packed {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic re_n;
        logic io_oe_n;
        logic [7:0] io_out;
    } nprpe_pins_s;
endpackage
